// ==== verif/core_seq_assertions.sv ====
// Port assertions for the core regulator sequencer
`timescale 1ns/1ps
module core_seq_assertions
    import core_seq_pkg::*;
#(parameter int unsigned POWER_OK_OUT_CYC = 50) (
    // Clock, reset and inputs
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       regulator_enable_in_i,
    input wire logic       upstream_power_ok_in_i,
    input wire logic       deeper_sleep_in_i,
    input wire logic       sleep_wake_in_n_i,
    input wire logic       forced_diode_emu_en_i,
    input wire logic       output_in_window_i,
    input wire logic       thermistor_sense_hot_i,
    // Outputs
    input wire logic       regulate_o,
    input wire logic       continuous_conduction_o,
    input wire logic       diode_emulation_o,
    input wire logic       wide_hysteresis_o,
    input wire logic [1:0] slew_sel_o,
    input wire logic [6:0] target_code_o,
    input wire logic       clk_en_n_o,
    input wire logic       power_ok_out_o,
    input wire logic       thermal_alert_oe_o
);
    localparam int PG_LO = POWER_OK_OUT_CYC - 2;
    localparam int PG_HI = POWER_OK_OUT_CYC + 2;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_boot;
        regulate_o && clk_en_n_o && $past(clk_en_n_o);
    endsequence
    sequence s_run;
        !clk_en_n_o && !$past(clk_en_n_o) && regulator_enable_in_i && upstream_power_ok_in_i;
    endsequence
    AST_CCM: assert property (s_boot |-> continuous_conduction_o && !diode_emulation_o)
        else $error("mode not forced during start-up");
    AST_SLOW: assert property (s_boot |-> slew_sel_o == SLEW_SLOW)
        else $error("slew not slow during ramp");
    AST_BOOT: assert property (s_boot |-> target_code_o == BOOT_CODE)
        else $error("target not boot level during ramp");
    AST_CLKEN: assert property ($fell(clk_en_n_o) |->
        $past(upstream_power_ok_in_i, 2) && $past(output_in_window_i, 2))
        else $error("clock enable without window and power ok");
    AST_PG_LATE: assert property ($fell(clk_en_n_o) |-> ##[PG_LO:PG_HI] power_ok_out_o)
        else $error("power good late");
    AST_PG_EARLY: assert property ($rose(power_ok_out_o) |-> $past(clk_en_n_o, PG_LO) == 1'b0)
        else $error("power good early");
    AST_LATCH: assert property (!upstream_power_ok_in_i && !clk_en_n_o |->
        ##[1:2] clk_en_n_o && !power_ok_out_o)
        else $error("power ok loss did not latch off");
    AST_OFF: assert property (!regulator_enable_in_i |->
        ##[1:2] clk_en_n_o && !regulate_o && !power_ok_out_o)
        else $error("enable low did not stop");
    AST_WIDE: assert property (s_run ##0 ($past(forced_diode_emu_en_i) && !$past(sleep_wake_in_n_i))
        |-> wide_hysteresis_o && diode_emulation_o)
        else $error("forced emulation not selected");
    AST_DEEP: assert property (s_run ##0 !$past(sleep_wake_in_n_i) |-> diode_emulation_o)
        else $error("sleep wake low not emulation");
    AST_FAST: assert property (s_run ##0 (!deeper_sleep_in_i && !$past(deeper_sleep_in_i))
        |-> slew_sel_o == SLEW_FAST)
        else $error("slew not fast when running");
    AST_SLEEP: assert property (s_run ##0 (deeper_sleep_in_i && $past(deeper_sleep_in_i))
        |-> slew_sel_o == SLEW_SLOW)
        else $error("slew not slow in deeper sleep");
    AST_ALERT: assert property (thermistor_sense_hot_i |-> ##[1:2] thermal_alert_oe_o)
        else $error("thermal alert not driven");
    C_CLKEN: cover property ($fell(clk_en_n_o));
    C_POWER_OK_OUT: cover property ($rose(power_ok_out_o));
    C_WIDE: cover property ($rose(wide_hysteresis_o));
endmodule
bind core_regulator_sequencer core_seq_assertions #(.POWER_OK_OUT_CYC(POWER_OK_OUT_CYC)) i_core_seq_assertions (
    .ref_clk_i, .sys_rst_i, .regulator_enable_in_i, .upstream_power_ok_in_i, .deeper_sleep_in_i,
    .sleep_wake_in_n_i, .forced_diode_emu_en_i, .output_in_window_i, .thermistor_sense_hot_i,
    .regulate_o, .continuous_conduction_o, .diode_emulation_o, .wide_hysteresis_o, .slew_sel_o,
    .target_code_o, .clk_en_n_o, .power_ok_out_o, .thermal_alert_oe_o);

// ==== verif/pm_partner.sv ====
// Chipset power-ok model facing the sequencer
`timescale 1ns/1ps
module pm_partner #(parameter int unsigned OK_DELAY = 30) (
    input  wire logic ref_clk_i,
    input  wire logic regulator_enable_in_i,
    input  wire logic drop_i,
    output logic      upstream_power_ok_o
);
    int unsigned cnt = 0;
    // Power ok rises a while after enable, falls on a drop command
    always_ff @(posedge ref_clk_i) begin
        if (!regulator_enable_in_i || drop_i) cnt <= 0;
        else if (cnt < OK_DELAY) cnt <= cnt + 1;
    end
    assign upstream_power_ok_o = (cnt == OK_DELAY);
endmodule

// ==== verif/test_core_regulator_sequencer.sv ====
// Self-checking bench for the core regulator sequencer
`timescale 1ns/1ps
module test_core_regulator_sequencer;
    import core_seq_pkg::*;
    localparam int unsigned PG = 50;
    logic ref_clk_i = 0, sys_rst_i = 1, en = 0, deep = 1, wake_n = 0, fde = 1, win = 1;
    logic hot = 0, drop = 0, wr = 0, rd = 0, pok, cen_n, power_ok_out, reg_o, continuous_conduction, diode_emulation, wide, oe, al_n, irq;
    logic [3:0] addr = 0;
    logic [7:0] wdata = 0, rdata, v;
    logic [6:0] code = 7'h2B, tgt;
    logic [1:0] slew;
    int errors = 0, checks_done = 0, n;
    wire pin = oe ? al_n : 1'b1;
    initial forever #25 ref_clk_i = ~ref_clk_i;
    pm_partner i_pm_partner (.ref_clk_i(ref_clk_i), .regulator_enable_in_i(en), .drop_i(drop),
        .upstream_power_ok_o(pok));
    core_regulator_sequencer #(.POWER_OK_OUT_CYC(PG)) i_core_regulator_sequencer (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .regulator_enable_in_i(en),
        .upstream_power_ok_in_i(pok), .deeper_sleep_in_i(deep), .sleep_wake_in_n_i(wake_n),
        .forced_diode_emu_en_i(fde), .voltage_code_i(code), .output_in_window_i(win),
        .thermistor_sense_hot_i(hot), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .regulate_o(reg_o),
        .continuous_conduction_o(continuous_conduction), .diode_emulation_o(diode_emulation), .wide_hysteresis_o(wide),
        .slew_sel_o(slew), .target_code_o(tgt), .clk_en_n_o(cen_n), .power_ok_out_o(power_ok_out),
        .thermal_alert_out_n_o(al_n), .thermal_alert_oe_o(oe));
    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        #1;
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge ref_clk_i);
    endtask
    task automatic rdreg(logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        rd <= 1;
        addr <= a;
        @(posedge ref_clk_i);
        rd <= 0;
        #1 d = rdata;
    endtask
    task automatic wrreg(logic [3:0] a, logic [7:0] d);
        @(posedge ref_clk_i);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk_i);
        wr <= 0;
    endtask
    task automatic wait_run();
        n = 0;
        while (cen_n !== 1'b0 && n < 5000) begin
            tick(1);
            #1;
            n++;
        end
        if (n >= 5000) begin
            errors++;
            report_and_stop();
        end
    endtask
    task automatic s_start();
        tick(1);
        en <= 1;
        tick(START_DELAY_CYC - 10);
        chk("slew", SLEW_OFF, slew);
        chk("regulate", 0, reg_o);
        tick(210);
        chk("ccm", 1, continuous_conduction);
        chk("slew", SLEW_SLOW, slew);
        chk("target", BOOT_CODE, tgt);
        chk("regulate", 1, reg_o);
        chk("clk_en_n", 1, cen_n);
        tick(1);
        win <= 0;
        tick(10);
        win <= 1;
        wait_run();
        chk("hold", 1, n >= PG_HOLD_CYC && n <= PG_HOLD_CYC + 5);
        tick(PG - 4);
        chk("power_ok_out", 0, power_ok_out);
        tick(6);
        chk("power_ok_out", 1, power_ok_out);
        chk("target", 7'h2B, tgt);
        chk("slew", SLEW_SLOW, slew);
        chk("modes", 3'h3, {continuous_conduction, wide, diode_emulation});
        tick(1);
        code <= 7'h54;
        deep <= 0;
        fde <= 0;
        tick(3);
        chk("target", 7'h54, tgt);
        chk("slew", SLEW_FAST, slew);
        chk("modes", 3'h1, {continuous_conduction, wide, diode_emulation});
        tick(1);
        wake_n <= 1;
        tick(3);
        chk("modes", 3'h4, {continuous_conduction, wide, diode_emulation});
        tick(1);
        deep <= 1;
        tick(3);
        chk("slew", SLEW_SLOW, slew);
        chk("dem", 1, diode_emulation);
    endtask
    task automatic s_latch();
        tick(1);
        drop <= 1;
        tick(1);
        drop <= 0;
        tick(3);
        chk("clk_en_n", 1, cen_n);
        chk("power_ok_out", 0, power_ok_out);
        tick(60);
        chk("power_ok_in", 1, pok);
        chk("latched", 2'h2, {cen_n, power_ok_out});
        rdreg(ADDR_STATE, v);
        chk("state", ST_LATCHED, v);
        rdreg(ADDR_STATUS, v);
        chk("status", 1, v[0]);
        chk("irq", 0, irq);
        wrreg(ADDR_MASK, 8'h01);
        tick(2);
        chk("irq", 1, irq);
        wrreg(ADDR_STATUS, 8'h03);
        tick(2);
        chk("irq", 0, irq);
        tick(1);
        en <= 0;
        tick(3);
        chk("regulate", 0, reg_o);
        tick(1);
        en <= 1;
        wait_run();
        chk("restart", 0, cen_n);
    endtask
    task automatic s_therm();
        wrreg(ADDR_MASK, 8'h04);
        hot <= 1;
        tick(3);
        chk("alert", 0, pin);
        chk("irq", 1, irq);
        tick(1);
        hot <= 0;
        wrreg(ADDR_STATUS, 8'h04);
        tick(2);
        chk("alert", 1, pin);
        chk("irq", 0, irq);
        tick(PG);
        chk("power_ok_out", 1, power_ok_out);
        tick(1);
        en <= 0;
        tick(3);
        chk("off", 2'h2, {cen_n, power_ok_out});
    endtask
    initial begin
        tick(4);
        chk("rst", 2'h2, {cen_n, power_ok_out});
        tick(1);
        sys_rst_i <= 0;
        rdreg(ADDR_MASK, v);
        chk("mask", MASK_RESET, v);
        rdreg(4'h1, v);
        chk("unmapped", 0, v);
        s_start();
        s_latch();
        s_therm();
        report_and_stop();
    end
endmodule

// ==== verilog/core_regulator_sequencer.sv ====
// Start-up, mode and protection sequencer of a core regulator
`timescale 1ns/1ps
module core_regulator_sequencer
    import core_seq_pkg::*;
#(
    parameter int unsigned POWER_OK_OUT_CYC = POWER_OK_OUT_DELAY_CYC
) (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // Power management inputs
    input  wire logic       regulator_enable_in_i,
    input  wire logic       upstream_power_ok_in_i,
    input  wire logic       deeper_sleep_in_i,
    input  wire logic       sleep_wake_in_n_i,
    input  wire logic       forced_diode_emu_en_i,
    input  wire logic [6:0] voltage_code_i,
    // Analog status inputs
    input  wire logic       output_in_window_i,
    input  wire logic       thermistor_sense_hot_i,
    // Register port
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic            irq_o,
    // Regulator control outputs
    output logic            regulate_o,
    output logic            continuous_conduction_o,
    output logic            diode_emulation_o,
    output logic            wide_hysteresis_o,
    output logic      [1:0] slew_sel_o,
    output logic      [6:0] target_code_o,
    output logic            clk_en_n_o,
    output logic            power_ok_out_o,
    output logic            thermal_alert_out_n_o,
    output logic            thermal_alert_oe_o
);

    seq_state_type          state;
    logic [CNT_W-1:0]       count;
    logic                   enable_q;
    logic [ST_W-1:0]        status;
    logic [ST_W-1:0]        mask;
    logic                   force_ccm;
    logic [ST_W-1:0]        events;

    wire enable_rise = regulator_enable_in_i & ~enable_q;
    wire in_startup  = (state == ST_DELAY) || (state == ST_RAMP);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enable_q <= 1'b0;
        end else begin
            enable_q <= regulator_enable_in_i;
        end
    end

    // Sequencer state and its timer
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_OFF;
            count <= '0;
        end else if (!regulator_enable_in_i) begin
            state <= ST_OFF;
            count <= '0;
        end else begin
            unique case (state)
                ST_OFF: begin
                    count <= '0;
                    if (enable_rise) begin
                        state <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (count == CNT_W'(START_DELAY_CYC - 1)) begin
                        state <= ST_RAMP;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_RAMP: begin
                    if (!(output_in_window_i && upstream_power_ok_in_i)) begin
                        count <= '0;
                    end else if (count == CNT_W'(PG_HOLD_CYC - 1)) begin
                        state <= ST_ACTIVE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (!upstream_power_ok_in_i) begin
                        state <= ST_LATCHED;
                    end else if (count == CNT_W'(POWER_OK_OUT_CYC - 1)) begin
                        state <= ST_GOOD;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                ST_GOOD: begin
                    if (!upstream_power_ok_in_i) begin
                        state <= ST_LATCHED;
                    end
                end
                ST_LATCHED: begin
                    state <= ST_LATCHED;
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // Start-up has handed over to normal regulation
    function automatic logic is_running(input seq_state_type s);
        return (s == ST_ACTIVE) || (s == ST_GOOD);
    endfunction

    // Boot settings hold from off through ramp and while latched
    function automatic logic holds_boot(input seq_state_type s);
        return (s == ST_OFF) || (s == ST_DELAY) || (s == ST_RAMP) || (s == ST_LATCHED);
    endfunction

    // Emulation request from the sleep and forced-emulation inputs
    function automatic logic wants_emulation(input logic deep,
                                             input logic wake_n,
                                             input logic forced);
        return deep || !wake_n || (forced && !wake_n);
    endfunction

    // Register write decode
    function automatic logic write_hit(input logic       wr,
                                       input logic [3:0] addr,
                                       input logic [3:0] target);
        return wr && (addr == target);
    endfunction

    // Regulation enable
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            regulate_o <= 1'b0;
        end else begin
            regulate_o <= (state == ST_RAMP) || is_running(state);
        end
    end

    // Clock enable, active low
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_en_n_o <= 1'b1;
        end else begin
            clk_en_n_o <= !is_running(state);
        end
    end

    // Power good
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            power_ok_out_o <= 1'b0;
        end else begin
            power_ok_out_o <= (state == ST_GOOD);
        end
    end

    // Conduction mode
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            continuous_conduction_o <= 1'b1;
            diode_emulation_o       <= 1'b0;
            wide_hysteresis_o       <= 1'b0;
        end else if (holds_boot(state)) begin
            continuous_conduction_o <= 1'b1;
            diode_emulation_o       <= 1'b0;
            wide_hysteresis_o       <= 1'b0;
        end else begin
            continuous_conduction_o <= !wants_emulation(deeper_sleep_in_i,
                                                        sleep_wake_in_n_i,
                                                        forced_diode_emu_en_i);
            diode_emulation_o       <= wants_emulation(deeper_sleep_in_i,
                                                       sleep_wake_in_n_i,
                                                       forced_diode_emu_en_i);
            wide_hysteresis_o       <= forced_diode_emu_en_i && !sleep_wake_in_n_i;
        end
    end

    // Target voltage code
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            target_code_o <= BOOT_CODE;
        end else if (holds_boot(state)) begin
            target_code_o <= BOOT_CODE;
        end else begin
            target_code_o <= voltage_code_i;
        end
    end

    // Slew current selection
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slew_sel_o <= SLEW_OFF;
        end else if (state == ST_RAMP) begin
            slew_sel_o <= SLEW_SLOW;
        end else if (holds_boot(state)) begin
            slew_sel_o <= SLEW_OFF;
        end else if (deeper_sleep_in_i) begin
            slew_sel_o <= SLEW_SLOW;
        end else begin
            slew_sel_o <= SLEW_FAST;
        end
    end

    // Thermal alert, open drain
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            thermal_alert_out_n_o <= 1'b1;
            thermal_alert_oe_o    <= 1'b0;
        end else begin
            thermal_alert_out_n_o <= 1'b0;
            thermal_alert_oe_o    <= thermistor_sense_hot_i;
        end
    end

    logic [ST_W-1:0]        status_clear;

    assign force_ccm = in_startup;
    assign events = {thermistor_sense_hot_i,
                     (state == ST_ACTIVE) && (count == CNT_W'(POWER_OK_OUT_CYC - 1)),
                     is_running(state) && !upstream_power_ok_in_i && regulator_enable_in_i};
    assign status_clear = {ST_W{write_hit(reg_wr_i, reg_addr_i, ADDR_STATUS)}}
                          & reg_wdata_i[ST_W-1:0];

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status <= '0;
        end else begin
            for (int i = 0; i < ST_W; i++) begin
                if (events[i]) begin
                    status[i] <= 1'b1;
                end else if (status_clear[i]) begin
                    status[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask <= MASK_RESET;
        end else if (write_hit(reg_wr_i, reg_addr_i, ADDR_MASK)) begin
            mask <= reg_wdata_i[ST_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask);
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                ADDR_CTRL:   reg_rdata_o <= {6'h00, force_ccm, regulator_enable_in_i};
                ADDR_STATUS: reg_rdata_o <= {5'h00, status};
                ADDR_MASK:   reg_rdata_o <= {5'h00, mask};
                ADDR_STATE:  reg_rdata_o <= {5'h00, state};
                default:     reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

// ==== verilog/core_seq_pkg.sv ====
// Constants and types shared by the core regulator sequencer
package core_seq_pkg;

    // Clock rate and derived timing
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned START_DELAY_US   = 100;
    localparam int unsigned START_DELAY_CYC  = START_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned PG_HOLD_US       = 20;
    localparam int unsigned PG_HOLD_CYC      = PG_HOLD_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned POWER_OK_OUT_DELAY_MS   = 7;
    localparam int unsigned POWER_OK_OUT_DELAY_CYC  = POWER_OK_OUT_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W            = 18;

    // Boot level as voltage code (1.2 V)
    localparam logic [6:0]  BOOT_CODE        = 7'h18;

    // Slew current selections
    localparam logic [1:0]  SLEW_OFF         = 2'h0;
    localparam logic [1:0]  SLEW_SLOW        = 2'h1;
    localparam logic [1:0]  SLEW_FAST        = 2'h2;

    // Status and mask bit positions
    localparam int unsigned ST_LATCH         = 0;
    localparam int unsigned ST_POWER_OK_OUT         = 1;
    localparam int unsigned ST_THERM         = 2;
    localparam int unsigned ST_W             = 3;

    // Register map
    localparam logic [3:0]  ADDR_CTRL        = 4'h0;
    localparam logic [3:0]  ADDR_STATUS      = 4'h4;
    localparam logic [3:0]  ADDR_MASK        = 4'h8;
    localparam logic [3:0]  ADDR_STATE       = 4'hC;
    localparam logic [ST_W-1:0] MASK_RESET   = 3'h0;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_DELAY  = 3'b001,
        ST_RAMP   = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_GOOD   = 3'b100,
        ST_LATCHED = 3'b101
    } seq_state_type;

endpackage
